// File: verilog/sta_pkg.sv
package sta_pkg;

    // resolution and bus widths
    localparam int unsigned ADC_BITS_DEF = 12;
    localparam int unsigned APB_AW = 8;
    localparam int unsigned APB_DW = 32;

    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
    localparam logic [7:0] OFS_IRQ_EN = 8'h14;
    localparam logic [7:0] OFS_CMD = 8'h18;

    // control fields
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned CTRL_MODE_BIT = 1;

    // status fields
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_READY_BIT = 1;
    localparam int unsigned STAT_LOCK_BIT = 2;
    localparam int unsigned STAT_MODE_BIT = 3;
    localparam int unsigned STAT_EN_BIT = 4;

    // event fields, shared by irq status, clear and enable
    localparam int unsigned EV_W = 3;
    localparam int unsigned EV_LOCK_BIT = 0;
    localparam int unsigned EV_READY_BIT = 1;
    localparam int unsigned EV_DONE_BIT = 2;

    // command fields
    localparam int unsigned CMD_START_BIT = 0;

    // reset values
    localparam logic CTRL_EN_RST = 1'h0;
    localparam logic CTRL_MODE_RST = 1'h0;
    localparam logic [EV_W-1:0] IRQ_EN_RST = 3'h0;

    typedef enum logic {
        STA_MODE_TRACK,
        STA_MODE_SAR
    } sta_mode_type;

    typedef enum logic {
        SAR_IDLE,
        SAR_RUN
    } sta_sar_state_type;

endpackage : sta_pkg

// File: verilog/sta_track.sv
`timescale 1ns/1ps
module sta_track #(
    parameter int unsigned RES = sta_pkg::ADC_BITS_DEF
) (
    input logic pclk,
    input logic presetn,
    input logic enable,
    input logic cmp_up,
    input logic cmp_dn,
    output logic [RES-1:0] code_nxt,
    output logic ready_nxt,
    output logic locked
);
    import sta_pkg::*;

    localparam logic [RES-1:0] CODE_MAX = '1;
    localparam logic [RES-1:0] CODE_MIN = '0;

    typedef struct packed {
        logic [RES-1:0] code;
        logic ready;
        logic locked;
    } sta_trk_type;

    sta_trk_type s_r;
    sta_trk_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ready = 1'b0;
        if (!enable) begin
            s_nxt = '0;
        end else if (!s_r.locked) begin
            // acquisition: climb until the dac reaches the input or full scale
            if (cmp_up && s_r.code != CODE_MAX) begin
                s_nxt.code = s_r.code + 1'b1;
            end else begin
                s_nxt.locked = 1'b1;
            end
        end else if (!cmp_up && !cmp_dn) begin
            s_nxt.ready = 1'b1;
        end else if (cmp_up) begin
            if (s_r.code != CODE_MAX) begin
                s_nxt.code = s_r.code + 1'b1;
            end
        end else begin
            if (s_r.code != CODE_MIN) begin
                s_nxt.code = s_r.code - 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign code_nxt = s_nxt.code;
    assign ready_nxt = s_nxt.ready;
    assign locked = s_r.locked;

endmodule : sta_track

// File: verilog/sta_sar.sv
`timescale 1ns/1ps
module sta_sar #(
    parameter int unsigned RES = sta_pkg::ADC_BITS_DEF
) (
    input logic pclk,
    input logic presetn,
    input logic start,
    input logic abort,
    input logic cmp_gt,
    output logic [RES-1:0] code_nxt,
    output logic busy_nxt,
    output logic done_nxt
);
    import sta_pkg::*;

    localparam logic [RES-1:0] MSB_ONE = {1'b1, {(RES-1){1'b0}}};

    typedef struct packed {
        sta_sar_state_type state;
        logic [RES-1:0] code;
        logic [RES-1:0] mask;
        logic done;
    } sta_sar_type;

    sta_sar_type s_r;
    sta_sar_type s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (abort) begin
            s_nxt.state = SAR_IDLE;
            s_nxt.mask = '0;
        end else if (start) begin
            s_nxt.state = SAR_RUN;
            s_nxt.code = MSB_ONE;
            s_nxt.mask = MSB_ONE;
        end else begin
            case (s_r.state)
                SAR_IDLE: begin
                    s_nxt.mask = '0;
                end
                SAR_RUN: begin
                    // decide trial bit, raise the next one
                    s_nxt.code = (s_r.code & ~(s_r.mask & {RES{~cmp_gt}}))
                        | (s_r.mask >> 1);
                    s_nxt.mask = s_r.mask >> 1;
                    if (s_r.mask[0]) begin
                        s_nxt.state = SAR_IDLE;
                        s_nxt.done = 1'b1;
                    end
                end
                default: begin
                    s_nxt.state = SAR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign code_nxt = s_nxt.code;
    assign busy_nxt = (s_nxt.state == SAR_RUN);
    assign done_nxt = s_nxt.done;

endmodule : sta_sar

// File: verilog/sta_adc_ctrl.sv
`timescale 1ns/1ps
module sta_adc_ctrl #(
    parameter int unsigned RES = sta_pkg::ADC_BITS_DEF
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [sta_pkg::APB_AW-1:0] paddr,
    input logic [sta_pkg::APB_DW-1:0] pwdata,
    output logic [sta_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic cmp_up,
    input logic cmp_dn,
    input logic cmp_gt,
    input logic start_n,
    output logic [RES-1:0] dac_code,
    output logic data_ready,
    output logic busy,
    output logic irq
);
    import sta_pkg::*;

    typedef struct packed {
        logic ctrl_en;
        sta_mode_type ctrl_mode;
        logic [EV_W-1:0] irq_en;
        logic [EV_W-1:0] irq_stat;
        logic [APB_DW-1:0] prdata;
        logic pready;
        logic pslverr;
        logic [RES-1:0] dac_code;
        logic data_ready;
        logic busy;
        logic irq;
        logic start_prev;
        logic lock_prev;
    } sta_top_type;

    sta_top_type s_r;
    sta_top_type s_nxt;

    logic [RES-1:0] trk_code_nxt;
    logic trk_ready_nxt;
    logic trk_locked;
    logic [RES-1:0] sar_code_nxt;
    logic sar_busy_nxt;
    logic sar_done_nxt;
    logic trk_enable;
    logic sar_active;
    logic sar_start;
    logic sar_abort;
    logic wr_fire;
    logic cmd_start;
    logic pin_start;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] irq_clr;

    function automatic logic sta_addr_ok(input logic [APB_AW-1:0] a);
        sta_addr_ok = (a == OFS_CTRL) || (a == OFS_STATUS)
            || (a == OFS_RESULT) || (a == OFS_IRQ_STAT)
            || (a == OFS_IRQ_CLR) || (a == OFS_IRQ_EN)
            || (a == OFS_CMD);
    endfunction : sta_addr_ok

    function automatic logic [APB_DW-1:0] sta_rd_mux(
        input logic [APB_AW-1:0] a,
        input sta_top_type st,
        input logic locked
    );
        logic [APB_DW-1:0] d;
        d = '0;
        case (a)
            OFS_CTRL: begin
                d[CTRL_EN_BIT] = st.ctrl_en;
                d[CTRL_MODE_BIT] = (st.ctrl_mode == STA_MODE_SAR);
            end
            OFS_STATUS: begin
                d[STAT_BUSY_BIT] = st.busy;
                d[STAT_READY_BIT] = st.data_ready;
                d[STAT_LOCK_BIT] = locked;
                d[STAT_MODE_BIT] = (st.ctrl_mode == STA_MODE_SAR);
                d[STAT_EN_BIT] = st.ctrl_en;
            end
            OFS_RESULT: begin
                d[RES-1:0] = st.dac_code;
            end
            OFS_IRQ_STAT: begin
                d[EV_W-1:0] = st.irq_stat;
            end
            OFS_IRQ_EN: begin
                d[EV_W-1:0] = st.irq_en;
            end
            default: begin
                d = '0;
            end
        endcase
        sta_rd_mux = d;
    endfunction : sta_rd_mux

    // apb write lands at the access edge with pready high
    assign wr_fire = psel && penable && s_r.pready && pwrite
        && sta_addr_ok(paddr);
    assign cmd_start = wr_fire && (paddr == OFS_CMD)
        && pwdata[CMD_START_BIT];
    assign irq_clr = (wr_fire && paddr == OFS_IRQ_CLR) ?
        pwdata[EV_W-1:0] : '0;

    assign trk_enable = s_r.ctrl_en && (s_r.ctrl_mode == STA_MODE_TRACK);
    assign sar_active = s_r.ctrl_en && (s_r.ctrl_mode == STA_MODE_SAR);

    // low-going edge on the start pin
    assign pin_start = s_r.start_prev && !start_n;
    assign sar_start = sar_active && (pin_start || cmd_start);
    assign sar_abort = !sar_active;

    sta_track #(
        .RES(RES)
    ) u_track (
        .pclk(pclk),
        .presetn(presetn),
        .enable(trk_enable),
        .cmp_up(cmp_up),
        .cmp_dn(cmp_dn),
        .code_nxt(trk_code_nxt),
        .ready_nxt(trk_ready_nxt),
        .locked(trk_locked)
    );

    sta_sar #(
        .RES(RES)
    ) u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(sar_start),
        .abort(sar_abort),
        .cmp_gt(cmp_gt),
        .code_nxt(sar_code_nxt),
        .busy_nxt(sar_busy_nxt),
        .done_nxt(sar_done_nxt)
    );

    // events: first lock, ready rising, conversion done
    always_comb begin
        ev = '0;
        ev[EV_LOCK_BIT] = trk_locked && !s_r.lock_prev;
        ev[EV_READY_BIT] = trk_enable && trk_ready_nxt && !s_r.data_ready;
        ev[EV_DONE_BIT] = sar_active && sar_done_nxt;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.start_prev = start_n;
        s_nxt.lock_prev = trk_locked;

        // apb slave: answer in the first access cycle
        s_nxt.pready = psel && !penable;
        s_nxt.pslverr = psel && !penable && !sta_addr_ok(paddr);
        if (psel && !penable) begin
            s_nxt.prdata = pwrite ? '0 : sta_rd_mux(paddr, s_r, trk_locked);
        end

        if (wr_fire && paddr == OFS_CTRL) begin
            s_nxt.ctrl_en = pwdata[CTRL_EN_BIT];
            s_nxt.ctrl_mode = pwdata[CTRL_MODE_BIT] ?
                STA_MODE_SAR : STA_MODE_TRACK;
        end
        if (wr_fire && paddr == OFS_IRQ_EN) begin
            s_nxt.irq_en = pwdata[EV_W-1:0];
        end

        // a new event beats a clear in the same cycle
        s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | ev;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_en);

        // dac code tracks the active engine's register exactly
        if (s_r.ctrl_mode == STA_MODE_SAR) begin
            s_nxt.dac_code = sar_code_nxt;
            s_nxt.data_ready = 1'b0;
            s_nxt.busy = sar_active && sar_busy_nxt;
        end else begin
            s_nxt.dac_code = trk_code_nxt;
            s_nxt.data_ready = trk_enable && trk_ready_nxt;
            s_nxt.busy = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.ctrl_en <= CTRL_EN_RST;
            s_r.ctrl_mode <= sta_mode_type'(CTRL_MODE_RST);
            s_r.irq_en <= IRQ_EN_RST;
            s_r.start_prev <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign dac_code = s_r.dac_code;
    assign data_ready = s_r.data_ready;
    assign busy = s_r.busy;
    assign irq = s_r.irq;

endmodule : sta_adc_ctrl

// File: verif/sta_afe_model.sv
`timescale 1ns/1ps
module sta_afe_model #(
    parameter int unsigned RES = 12
) (
    input logic [RES-1:0] ain,
    input logic [RES-1:0] dac_code,
    output logic cmp_up,
    output logic cmp_dn,
    output logic cmp_gt
);
    // error outside the half-step window, by polarity
    assign cmp_up = ain > dac_code;
    assign cmp_dn = ain < dac_code;
    // held input at or above the trial level
    assign cmp_gt = ain >= dac_code;
endmodule : sta_afe_model

// File: verif/sta_adc_ctrl_props.sv
`timescale 1ns/1ps
module sta_adc_ctrl_props #(
    parameter int unsigned RES = 12
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [sta_pkg::APB_AW-1:0] paddr,
    input logic [sta_pkg::APB_DW-1:0] pwdata,
    input logic [sta_pkg::APB_DW-1:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic cmp_up,
    input logic cmp_dn,
    input logic cmp_gt,
    input logic start_n,
    input logic [RES-1:0] dac_code,
    input logic data_ready,
    input logic busy,
    input logic irq
);
    import sta_pkg::*;
    logic en_r, mode_r, win_r, trk, sar, win;
    logic lk_r, sp_r, st;
    logic [7:0] cnt_r;
    logic [RES-1:0] t, sar_nxt;
    assign trk = en_r && !mode_r;
    assign sar = en_r && mode_r;
    assign win = trk && !cmp_up && !cmp_dn;
    assign t = dac_code & (~dac_code + 1'b1);
    assign sar_nxt = (cmp_gt ? dac_code : dac_code & ~t) | (t >> 1);
    // a start on the pin or by command, seen at this edge
    assign st = sar && ((sp_r && !start_n) || (psel && penable && pready
        && pwrite && paddr == OFS_CMD && pwdata[CMD_START_BIT]));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            mode_r <= 1'b0;
            win_r <= 1'b0;
            cnt_r <= 8'h00;
            lk_r <= 1'b0;
            sp_r <= 1'b1;
        end else begin
            if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
                en_r <= pwdata[CTRL_EN_BIT];
                mode_r <= pwdata[CTRL_MODE_BIT];
            end
            win_r <= win;
            cnt_r <= (busy && !st) ? cnt_r + 8'h01 : 8'h00;
            lk_r <= trk ? (lk_r || !cmp_up || dac_code == '1) : 1'b0;
            sp_r <= start_n;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_busy_len: assert property (sar && $fell(busy) |-> cnt_r == RES)
        else $error("busy length wrong");
    a_sar_first: assert property ($rose(busy) |->
        dac_code == {1'b1, {(RES-1){1'b0}}}) else $error("bad first trial");
    a_sar_step: assert property (busy && sar && !st |=>
        dac_code == $past(sar_nxt)) else $error("bad bit trial");
    a_sar_hold: assert property (sar && $past(sar) && !busy && !st |=>
        $stable(dac_code)) else $error("result moved");
    a_start_busy: assert property (sar && $fell(start_n) |=> busy)
        else $error("start ignored");
    a_trk_up: assert property (trk && cmp_up && dac_code != '1 |=>
        dac_code == $past(dac_code) + 1'b1) else $error("no up step");
    a_trk_down: assert property (trk && lk_r && cmp_dn && !cmp_up &&
        dac_code != '0 |=> dac_code == $past(dac_code) - 1'b1)
        else $error("no down step");
    a_trk_ready: assert property (win && win_r |=>
        data_ready && $stable(dac_code)) else $error("no hold");
    a_trk_busy: assert property (trk && (cmp_up || cmp_dn) |=>
        !data_ready) else $error("ready outside window");
    a_apb_ready: assert property (psel && !penable |=> pready)
        else $error("no apb answer");
    c_sar_done: cover property ($fell(busy));
    c_trk_hold: cover property (win && win_r);
    c_apb_err: cover property (pready && pslverr);
endmodule : sta_adc_ctrl_props

bind sta_adc_ctrl sta_adc_ctrl_props #(.RES(RES)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_up(cmp_up), .cmp_dn(cmp_dn), .cmp_gt(cmp_gt),
    .start_n(start_n), .dac_code(dac_code), .data_ready(data_ready),
    .busy(busy), .irq(irq));

// File: verif/tb_sta_adc_ctrl.sv
`timescale 1ns/1ps
module tb_sta_adc_ctrl;
    import sta_pkg::*;
    localparam int unsigned RES = 8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic start_n = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, cmp_up, cmp_dn, cmp_gt, data_ready, busy, irq, e;
    logic [RES-1:0] dac_code;
    logic [RES-1:0] ain = '0;
    logic [RES-1:0] tgt [3] = '{8'hF0, 8'hF4, 8'h00};
    logic [RES-1:0] sv [4] = '{8'hA5, 8'h00, 8'hFF, 8'h5A};
    int num_errors = 0;
    int check_count = 0;
    int n;

    sta_adc_ctrl #(.RES(RES)) u_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_up(cmp_up), .cmp_dn(cmp_dn),
        .cmp_gt(cmp_gt), .start_n(start_n), .dac_code(dac_code),
        .data_ready(data_ready), .busy(busy), .irq(irq));
    sta_afe_model #(.RES(RES)) u_afe (.ain(ain), .dac_code(dac_code),
        .cmp_up(cmp_up), .cmp_dn(cmp_dn), .cmp_gt(cmp_gt));

    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk(k < 20, 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic ramp(input logic [RES-1:0] v);
        while (ain != v) begin
            @(posedge pclk);
            ain <= ain < v ? ain + 1'b1 : ain - 1'b1;
            @(negedge pclk);
        end
        n = 0;
        while (dac_code !== v && n < 600) begin
            @(negedge pclk);
            n++;
        end
        repeat (3) @(negedge pclk);
    endtask : ramp

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        #200000;
        num_errors++;
        final_report();
    end

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        ain <= 8'hFF;
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        ramp(8'hFF);
        chk(dac_code, 8'hFF);
        chk(data_ready, 1'b1);
        apb(1'b0, OFS_RESULT, 32'h0000_0000);
        chk(rd, 32'h0000_00FF);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0016);
        apb(1'b1, OFS_IRQ_EN, 32'h0000_0001);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        apb(1'b1, OFS_IRQ_CLR, 32'h0000_0007);
        repeat (2) @(negedge pclk);
        chk(irq, 1'b0);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(e, 1'b1);
        chk(rd, 32'h0000_0000);
        $display("acquire test done");
        foreach (tgt[i]) begin
            ramp(tgt[i]);
            chk(dac_code, tgt[i]);
        end
        $display("follow test done");
        apb(1'b1, OFS_CTRL, 32'h0000_0003);
        apb(1'b0, OFS_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        foreach (sv[i]) begin
            ain <= sv[i];
            if (i == 3) begin
                apb(1'b1, OFS_CMD, 32'h0000_0001);
            end else begin
                @(posedge pclk);
                start_n <= 1'b0;
                @(posedge pclk);
                start_n <= 1'b1;
            end
            n = 0;
            do begin
                @(negedge pclk);
                n++;
            end while (busy === 1'b1 && n < 50);
            chk(n, RES + 1);
            chk(dac_code, sv[i]);
            apb(1'b0, OFS_RESULT, 32'h0000_0000);
            chk(rd, sv[i]);
        end
        apb(1'b0, OFS_IRQ_STAT, 32'h0000_0000);
        chk(rd[EV_DONE_BIT], 1'b1);
        $display("conversion test done");
        final_report();
    end
endmodule : tb_sta_adc_ctrl
